// file: nvh_host.sv
// Host controller that drives a nonvolatile SRAM through its pins
`timescale 1ns/1ps
// How it works
// - Write strobe stays high during reads
// - Busy line left high during accesses
// - Address changes only while deselected
// - Writes framed by select and strobe
// - Byte enables set before strobes fall
// - Six consecutive command reads, strobe high
// - Sixth command read data discarded
// - Store request pulse at least 15 ns
module nvh_host
    import nvh_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16,
    parameter int POWERUP_WAIT = POWERUP_RECALL_CYCLES,
    parameter int STORE_WAIT = STORE_CYCLES,
    parameter int COMMAND_WAIT = COMMAND_PROCESS_CYCLES + SOFT_RECALL_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire nvh_pkg::nvh_req_type req,
    output logic req_ready,
    output logic rsp_valid,
    output nvh_pkg::nvh_rsp_type rsp,
    output logic nv_busy,
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic upper_byte_enable_n,
    output logic lower_byte_enable_n,
    output logic [nvh_pkg::ADDR_MAX-1:0] addr,
    output logic [nvh_pkg::DATA_MAX-1:0] dq_out,
    output logic dq_oe_n,
    input wire logic [nvh_pkg::DATA_MAX-1:0] dq_in,
    output logic hw_store_busy_n_out,
    output logic hw_store_busy_n_oe_n,
    input wire logic hw_store_busy_n_in
);
    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (!((DATA_W == 8 && ADDR_W == 17) || (DATA_W == 16 && ADDR_W == 16))) begin : g_bad_org
        $error("nvh_host: organisation must be 17x8 or 16x16");
    end
    if (POWERUP_WAIT < 1 || STORE_WAIT < 1 || COMMAND_WAIT < 1 ||
        POWERUP_WAIT >= (1 << TIMER_W) || STORE_WAIT >= (1 << TIMER_W) ||
        COMMAND_WAIT >= (1 << TIMER_W)) begin : g_bad_wait
        $error("nvh_host: wait counts out of timer range");
    end

    localparam logic [TIMER_W-1:0] T_POWERUP = TIMER_W'(POWERUP_WAIT);
    localparam logic [TIMER_W-1:0] T_STORE = TIMER_W'(STORE_WAIT);
    localparam logic [TIMER_W-1:0] T_COMMAND = TIMER_W'(COMMAND_WAIT);
    localparam logic [TIMER_W-1:0] T_READ = TIMER_W'(READ_CYCLES + SYNC_CYCLES - 1);
    localparam logic [TIMER_W-1:0] T_WRITE = TIMER_W'(WRITE_CYCLES - 1);
    localparam logic [TIMER_W-1:0] T_PULSE = TIMER_W'(STORE_PULSE_CYCLES - 1);
    localparam logic [TIMER_W-1:0] T_RELEASE =
        TIMER_W'(NO_STORE_RELEASE_CYCLES + WRITE_GRACE_CYCLES);
    localparam logic [TIMER_W-1:0] T_SETTLE = TIMER_W'(BUSY_DRIVE_HIGH_CYCLES);

    typedef enum logic [7:0] {
        ST_POWERUP = 8'h01,
        ST_IDLE = 8'h02,
        ST_SETUP = 8'h04,
        ST_STROBE = 8'h08,
        ST_HOLD = 8'h10,
        ST_PULSE = 8'h20,
        ST_NVWAIT = 8'h40,
        ST_SETTLE = 8'h80
    } nvh_state_type;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    nvh_state_type state, next_state;
    nvh_req_type cur, next_cur;
    logic [2:0] soft_count, next_soft_count;
    logic wait_phase, next_wait_phase;
    logic next_req_ready, next_rsp_valid, next_nv_busy;
    nvh_rsp_type next_rsp;
    logic next_ce_n, next_we_n, next_oe_n;
    logic next_upper_byte_enable_n, next_lower_byte_enable_n;
    logic [ADDR_MAX-1:0] next_addr;
    logic [DATA_MAX-1:0] next_dq_out;
    logic next_dq_oe_n, next_busy_oe_n;
    logic timer_load;
    logic [TIMER_W-1:0] timer_value;
    logic timer_expired;
    logic busy_meta, busy_sync;
    logic [DATA_MAX-1:0] dq_meta, dq_sync;

    // ------------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_meta <= 1'h1;
            busy_sync <= 1'h1;
            dq_meta <= 16'h0000;
            dq_sync <= 16'h0000;
        end else begin
            busy_meta <= hw_store_busy_n_in;
            busy_sync <= busy_meta;
            dq_meta <= dq_in;
            dq_sync <= dq_meta;
        end
    end

    // Shared wait timer, loaded with the power-up recall wait at reset
    nvh_timer #(
        .WIDTH(TIMER_W),
        .RESET_VALUE(T_POWERUP)
    ) u_timer (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .load(timer_load),
        .value(timer_value),
        .expired(timer_expired)
    );

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_soft_count = soft_count;
        next_wait_phase = wait_phase;
        next_req_ready = 1'h0;
        next_rsp_valid = 1'h0;
        next_rsp = rsp;
        next_nv_busy = nv_busy;
        next_ce_n = ce_n;
        next_we_n = we_n;
        next_oe_n = oe_n;
        next_upper_byte_enable_n = upper_byte_enable_n;
        next_lower_byte_enable_n = lower_byte_enable_n;
        next_addr = addr;
        next_dq_out = dq_out;
        next_dq_oe_n = dq_oe_n;
        next_busy_oe_n = hw_store_busy_n_oe_n;
        timer_load = 1'h0;
        timer_value = T_STORE;
        unique case (state)
            ST_POWERUP: begin
                // Hold off until recall time has passed and busy is high
                if (timer_expired && busy_sync) begin
                    next_state = ST_IDLE;
                    next_req_ready = 1'h1;
                    next_nv_busy = 1'h0;
                end
            end
            ST_IDLE: begin
                next_req_ready = 1'h1;
                if (req_valid && req_ready) begin
                    next_req_ready = 1'h0;
                    next_cur = req;
                    if (req.kind == CMD_HW_STORE) begin
                        next_soft_count = 3'h0;
                        next_busy_oe_n = 1'h0;
                        next_nv_busy = 1'h1;
                        timer_load = 1'h1;
                        timer_value = T_PULSE;
                        next_state = ST_PULSE;
                    end else begin
                        // Address and lanes settle while the chip is deselected
                        next_addr = req.addr;
                        if (DATA_W == 8) begin
                            next_lower_byte_enable_n = 1'h0;
                            next_upper_byte_enable_n = 1'h1;
                        end else begin
                            next_lower_byte_enable_n = ~req.byte_en[0];
                            next_upper_byte_enable_n = ~req.byte_en[1];
                        end
                        next_dq_out = req.wdata;
                        next_dq_oe_n = (req.kind != CMD_WRITE);
                        if (req.kind != CMD_SOFT_READ) begin
                            next_soft_count = 3'h0;
                        end
                        next_state = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                // Select and the strobe fall together, never strobe first
                next_ce_n = 1'h0;
                if (cur.kind == CMD_WRITE) begin
                    next_we_n = 1'h0;
                    timer_value = T_WRITE;
                end else begin
                    next_oe_n = 1'h0;
                    timer_value = T_READ;
                end
                timer_load = 1'h1;
                next_state = ST_STROBE;
            end
            ST_STROBE: begin
                if (timer_expired) begin
                    next_ce_n = 1'h1;
                    next_we_n = 1'h1;
                    next_oe_n = 1'h1;
                    next_rsp.rdata = dq_sync;
                    if (DATA_W == 8) begin
                        next_rsp.rdata[15:8] = 8'h00;
                    end
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Data released one cycle after the strobe rose
                next_dq_oe_n = 1'h1;
                next_state = ST_IDLE;
                next_req_ready = 1'h1;
                if (cur.kind == CMD_READ) begin
                    next_rsp_valid = 1'h1;
                end else if (cur.kind == CMD_SOFT_READ) begin
                    if (soft_count == SOFT_SEQ_LEN - 3'h1) begin
                        // Sixth read completes the sequence; its data are dropped
                        next_soft_count = 3'h0;
                        next_nv_busy = 1'h1;
                        next_wait_phase = 1'h0;
                        timer_load = 1'h1;
                        timer_value = T_COMMAND;
                        next_req_ready = 1'h0;
                        next_state = ST_NVWAIT;
                    end else begin
                        next_soft_count = soft_count + 3'h1;
                        next_rsp_valid = 1'h1;
                    end
                end
            end
            ST_PULSE: begin
                if (timer_expired) begin
                    // Release the line; the device now owns it
                    next_busy_oe_n = 1'h1;
                    next_wait_phase = 1'h0;
                    timer_load = 1'h1;
                    timer_value = T_RELEASE;
                    next_state = ST_NVWAIT;
                end
            end
            ST_NVWAIT: begin
                if (!wait_phase) begin
                    if (timer_expired) begin
                        next_wait_phase = 1'h1;
                        timer_load = 1'h1;
                        timer_value = T_STORE;
                    end
                end else if (busy_sync || timer_expired) begin
                    timer_load = 1'h1;
                    timer_value = T_SETTLE;
                    next_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (timer_expired && busy_sync) begin
                    next_nv_busy = 1'h0;
                    next_req_ready = 1'h1;
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // Register sequencer state and every pin
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_POWERUP;
            cur <= '0;
            soft_count <= 3'h0;
            wait_phase <= 1'h0;
            req_ready <= 1'h0;
            rsp_valid <= 1'h0;
            rsp <= '0;
            nv_busy <= 1'h1;
            ce_n <= 1'h1;
            we_n <= 1'h1;
            oe_n <= 1'h1;
            upper_byte_enable_n <= 1'h1;
            lower_byte_enable_n <= 1'h1;
            addr <= 17'h0_0000;
            dq_out <= 16'h0000;
            dq_oe_n <= 1'h1;
            hw_store_busy_n_out <= 1'h0; // Only ever pulls low
            hw_store_busy_n_oe_n <= 1'h1;
        end else begin
            state <= next_state;
            cur <= next_cur;
            soft_count <= next_soft_count;
            wait_phase <= next_wait_phase;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp <= next_rsp;
            nv_busy <= next_nv_busy;
            ce_n <= next_ce_n;
            we_n <= next_we_n;
            oe_n <= next_oe_n;
            upper_byte_enable_n <= next_upper_byte_enable_n;
            lower_byte_enable_n <= next_lower_byte_enable_n;
            addr <= next_addr;
            dq_out <= next_dq_out;
            dq_oe_n <= next_dq_oe_n;
            hw_store_busy_n_out <= 1'h0;
            hw_store_busy_n_oe_n <= next_busy_oe_n;
        end
    end
endmodule

// file: nvh_host_monitor.sv
// Pin-level assertion checker for the nonvolatile SRAM host controller
`timescale 1ns/1ps
module nvh_host_monitor (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire nvh_pkg::nvh_req_type req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic nv_busy,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic upper_byte_enable_n,
    input wire logic lower_byte_enable_n,
    input wire logic [nvh_pkg::ADDR_MAX-1:0] addr,
    input wire logic hw_store_busy_n_oe_n,
    input wire logic hw_store_busy_n_in
);
    import nvh_pkg::*;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------------
    // Multi-step strobe shapes
    // ------------------------------------------------------------------
    sequence write_low;
        (!we_n && !ce_n)[*4] ##1 (we_n && ce_n);
    endsequence
    sequence store_low;
        (!hw_store_busy_n_oe_n)[*3] ##1 hw_store_busy_n_oe_n;
    endsequence

    // ------------------------------------------------------------------
    // Pin relations
    // ------------------------------------------------------------------
    chk_read_we_high: assert property ((!ce_n && !oe_n) |-> we_n)
        else $error("write strobe low during a read");
    chk_busy_line_free: assert property (!ce_n |-> hw_store_busy_n_oe_n)
        else $error("busy line pulled during an access");
    chk_addr_while_desel: assert property ($changed(addr) |-> ce_n)
        else $error("address moved while selected");
    chk_write_pulse_len: assert property ($fell(we_n) |-> write_low)
        else $error("write pulse shape wrong");
    chk_lanes_set_first: assert property ($fell(ce_n) |->
        $stable(upper_byte_enable_n) && $stable(lower_byte_enable_n))
        else $error("byte lanes moved with select");
    chk_read_latency: assert property ((req_valid && req_ready && req.kind == CMD_READ)
        |-> ##10 rsp_valid)
        else $error("read result not on time");
    chk_soft_read_strobe: assert property ((req_valid && req_ready && req.kind == CMD_SOFT_READ)
        |-> ##2 (!ce_n && !oe_n && we_n))
        else $error("command read strobes wrong");
    chk_store_pulse_len: assert property ($fell(hw_store_busy_n_oe_n) |-> store_low)
        else $error("store request pulse length wrong");
    chk_busy_holds_off: assert property (!hw_store_busy_n_in |-> ce_n)
        else $error("access while busy line low");
    chk_wait_blocks_io: assert property (nv_busy |-> (ce_n && !req_ready))
        else $error("access offered during nonvolatile wait");
endmodule

bind nvh_host nvh_host_monitor nvh_host_monitor_i (
    .mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .nv_busy(nv_busy), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .upper_byte_enable_n(upper_byte_enable_n),
    .lower_byte_enable_n(lower_byte_enable_n), .addr(addr),
    .hw_store_busy_n_oe_n(hw_store_busy_n_oe_n), .hw_store_busy_n_in(hw_store_busy_n_in)
);

// file: nvh_host_tb_top.sv
// Self-checking testbench for the nonvolatile SRAM host controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", nm, ex, got); end end
module nvh_host_tb_top;
    import nvh_pkg::*;
    logic mclk, sys_rst, req_valid, req_ready, rsp_valid, nv_busy, ce_n, we_n, oe_n;
    logic upper_byte_enable_n, lower_byte_enable_n, dq_oe_n, hsb_out, hsb_oe_n, pull_n;
    nvh_req_type req;
    nvh_rsp_type rsp;
    logic [16:0] addr;
    logic [15:0] dq_out, dq_dev, sh [256], ad [12], exp_d;
    logic [31:0] seed;
    logic [15:0] expq [$];
    int fail_count = 0, check_count = 0, n1, n2;
    wire logic [15:0] dq_in = dq_oe_n ? dq_dev : dq_out;
    wire logic hw_store_busy_n = (hsb_oe_n | hsb_out) & pull_n; // Pulled-up busy wire

    nvh_host #(.POWERUP_WAIT(20), .STORE_WAIT(50), .COMMAND_WAIT(20)) nvh_host_i (
        .mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp(rsp), .nv_busy(nv_busy), .ce_n(ce_n), .we_n(we_n),
        .oe_n(oe_n), .upper_byte_enable_n(upper_byte_enable_n),
        .lower_byte_enable_n(lower_byte_enable_n), .addr(addr), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .dq_in(dq_in), .hw_store_busy_n_out(hsb_out),
        .hw_store_busy_n_oe_n(hsb_oe_n), .hw_store_busy_n_in(hw_store_busy_n));
    nvh_sram_model nvh_sram_model_i (
        .mclk(mclk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .upper_byte_enable_n(upper_byte_enable_n), .lower_byte_enable_n(lower_byte_enable_n),
        .addr(addr), .dq_host(dq_in), .hw_store_busy_n(hw_store_busy_n), .dq_dev(dq_dev), .busy_pull_n(pull_n));

    always #2.5 mclk = ~mclk;

    // ------------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Offer a request at a falling edge and hold it until taken
    task automatic send(input nvh_cmd_type k, input logic [16:0] a, input logic [15:0] d,
                        input logic [1:0] be);
        int n;
        req_valid = 1'b1;
        req = '{kind: k, addr: a, wdata: d, byte_en: be};
        for (n = 0; n < 400 && req_ready !== 1'b1; n++) @(negedge mclk);
        if (n == 400) begin
            fail_count++;
            summarize();
        end
        @(negedge mclk);
    endtask

    // Withdraw the offer and count cycles until the port is free again
    task automatic wait_ready(output int n);
        req_valid = 1'b0;
        for (n = 0; n < 2000 && req_ready !== 1'b1; n++) @(negedge mclk);
        if (n == 2000) begin
            fail_count++;
            summarize();
        end
    endtask

    task automatic wr(input logic [16:0] a, input logic [15:0] d, input logic [1:0] be);
        if (be[1]) sh[a[7:0]][15:8] = d[15:8];
        if (be[0]) sh[a[7:0]][7:0] = d[7:0];
        send(CMD_WRITE, a, d, be);
    endtask

    task automatic rd(input nvh_cmd_type k, input logic [16:0] a);
        expq.push_back(sh[a[7:0]]);
        send(k, a, 16'h0000, 2'h3);
    endtask

    // ------------------------------------------------------------------
    // Result watcher: oldest note against each read result
    // ------------------------------------------------------------------
    always @(negedge mclk) begin
        if (rsp_valid === 1'b1) begin
            if (expq.size() == 0) `CHK("rsp count", 1'b0, 1'b1)
            else begin
                exp_d = expq.pop_front();
                `CHK("rsp data", exp_d, rsp.rdata)
            end
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        seed = 32'h2f9b;
        for (int i = 0; i < 256; i++) sh[i] = 16'h0000;
        repeat (10) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        `CHK("powerup busy", 1'b1, nv_busy)
        wait_ready(n1);
        // Back-to-back writes over every lane mix, then read back
        for (int i = 0; i < 12; i++) begin
            seed = lfsr_next(seed);
            ad[i] = seed[28:13];
            wr({seed[3], ad[i]}, seed[15:0], 2'(i % 3 + 1));
        end
        for (int i = 0; i < 12; i++) rd(CMD_READ, {1'b0, ad[i]});
        wr(17'h0_0011, 16'hc3a5, 2'h3);
        rd(CMD_READ, 17'h0_0011);
        // Six command reads; outer address bits random
        for (int k = 0; k < 6; k++) begin
            seed = lfsr_next(seed);
            if (k < 5) rd(CMD_SOFT_READ, {seed[6:5], 13'h0a00 + 13'(k), seed[1:0]});
            else send(CMD_SOFT_READ, {seed[6:5], 13'h0a05, seed[1:0]}, 16'h0000, 2'h3);
        end
        wait_ready(n1);
        `CHK("command lockout", 1'b1, n1 > 60)
        // Store with a pending write, then one with nothing to store
        wr(17'h0_0022, 16'h5e71, 2'h3);
        send(CMD_HW_STORE, 17'h0_0000, 16'h0000, 2'h0);
        `CHK("store busy", 1'b1, nv_busy)
        wait_ready(n1);
        send(CMD_HW_STORE, 17'h0_0000, 16'h0000, 2'h0);
        wait_ready(n2);
        `CHK("store skipped", 1'b1, n2 < n1)
        rd(CMD_READ, 17'h0_0022);
        wait_ready(n1);
        // Reset in mid-run returns pins to idle; the watcher still takes the oldest result first
        @(negedge mclk);
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        `CHK("reset select", 1'b1, ce_n)
        `CHK("reset ready", 1'b0, req_ready)
        sys_rst = 1'b0;
        wait_ready(n1);
        rd(CMD_READ, 17'h0_0011);
        wait_ready(n1);
        repeat (20) @(negedge mclk);
        `CHK("pending results", 0, expq.size())
        summarize();
    end
endmodule

// file: nvh_pkg.sv
// Shared constants and carrier types for the nonvolatile SRAM host controller
package nvh_pkg;

    // ------------------------------------------------------------------
    // Pin widths and clock
    // ------------------------------------------------------------------
    localparam int ADDR_MAX = 17;           // Widest organisation, byte-wide
    localparam int DATA_MAX = 16;           // Widest organisation, word-wide
    localparam int CLK_PERIOD_NS = 5;
    localparam int TIMER_W = 23;

    // ------------------------------------------------------------------
    // Timing in printed units and derived cycle counts
    // ------------------------------------------------------------------
    localparam int READ_CYCLE_NS = 25;
    localparam int WRITE_PULSE_NS = 20;
    localparam int STORE_REQUEST_PULSE_NS = 15;
    localparam int NO_STORE_RELEASE_TIME_NS = 25;
    localparam int WRITE_GRACE_TIME_NS = 25;
    localparam int BUSY_DRIVE_HIGH_TIME_NS = 500;
    localparam int POWERUP_RECALL_TIME_MS = 20;
    localparam int STORE_TIME_MS = 8;
    localparam int COMMAND_PROCESS_TIME_US = 100;
    localparam int SOFT_RECALL_TIME_US = 200;

    // Least times round up
    localparam int READ_CYCLES = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYCLES = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STORE_PULSE_CYCLES =
        (STORE_REQUEST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest times round down
    localparam int NO_STORE_RELEASE_CYCLES = NO_STORE_RELEASE_TIME_NS / CLK_PERIOD_NS;
    localparam int WRITE_GRACE_CYCLES = WRITE_GRACE_TIME_NS / CLK_PERIOD_NS;
    localparam int BUSY_DRIVE_HIGH_CYCLES = BUSY_DRIVE_HIGH_TIME_NS / CLK_PERIOD_NS;
    localparam int POWERUP_RECALL_CYCLES = POWERUP_RECALL_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int STORE_CYCLES = STORE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int COMMAND_PROCESS_CYCLES = COMMAND_PROCESS_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int SOFT_RECALL_CYCLES = SOFT_RECALL_TIME_US * 1000 / CLK_PERIOD_NS;

    // Input synchroniser latency on returning data
    localparam int SYNC_CYCLES = 2;
    // Reads in one software command sequence
    localparam logic [2:0] SOFT_SEQ_LEN = 3'h6;

    // ------------------------------------------------------------------
    // Request kinds and carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_READ = 2'h0,
        CMD_WRITE = 2'h1,
        CMD_SOFT_READ = 2'h2,
        CMD_HW_STORE = 2'h3
    } nvh_cmd_type;

    typedef struct packed {
        nvh_cmd_type kind;
        logic [ADDR_MAX-1:0] addr;
        logic [DATA_MAX-1:0] wdata;
        logic [1:0] byte_en;                // Bit 1 upper lane, bit 0 lower lane
    } nvh_req_type;

    typedef struct packed {
        logic [DATA_MAX-1:0] rdata;
    } nvh_rsp_type;

endpackage

// file: nvh_sram_model.sv
// Behavioural word-wide nonvolatile SRAM on the far side of the host pins
`timescale 1ns/1ps
module nvh_sram_model #(
    parameter logic [12:0] CMD_BASE = 13'h0a00, // Command address table start
    parameter int PU_NS = 300,
    parameter int SS_NS = 50,
    parameter int REC_NS = 300,
    parameter int STORE_NS = 150,
    parameter int GRACE_NS = 10
) (
    input wire logic mclk,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic upper_byte_enable_n,
    input wire logic lower_byte_enable_n,
    input wire logic [16:0] addr,
    input wire logic [15:0] dq_host,
    input wire logic hw_store_busy_n,
    output logic [15:0] dq_dev,
    output logic busy_pull_n
);
    logic [15:0] mem [256];
    logic [15:0] flt;
    logic pend;
    logic [2:0] seq;
    logic rd;
    event go_soft;

    // Array starts clear, busy held low through power-up recall
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
        pend = 1'b0;
        seq = 3'h0;
        flt = 16'h5a5a;
        busy_pull_n = 1'b0;
        #(PU_NS) busy_pull_n = 1'b1;
    end

    // Released lanes show a pattern that changes every cycle
    always @(posedge mclk) flt <= ~flt;

    // Reads drive enabled lanes only; write-first selection stays floating
    assign rd = !ce_n && we_n && !oe_n && busy_pull_n;
    assign dq_dev = {(rd && !upper_byte_enable_n) ? mem[addr[7:0]][15:8] : flt[15:8],
                     (rd && !lower_byte_enable_n) ? mem[addr[7:0]][7:0] : flt[7:0]};

    // Writes land on enabled lanes and arm the store latch
    always @* begin
        if (!ce_n && !we_n && busy_pull_n) begin
            if (!upper_byte_enable_n) mem[addr[7:0]][15:8] = dq_host[15:8];
            if (!lower_byte_enable_n) mem[addr[7:0]][7:0] = dq_host[7:0];
            pend = 1'b1;
            seq = 3'h0;
        end
    end

    // Command sequence tracked on address bits 14 to 2 only
    always @(negedge ce_n) begin
        if (we_n && busy_pull_n) begin
            seq = (addr[14:2] == CMD_BASE + 13'(seq)) ? seq + 3'h1 : 3'(addr[14:2] == CMD_BASE);
            if (seq == 3'h6) begin
                seq = 3'h0;
                -> go_soft;
            end
        end
    end

    // Command acted on, then recall locks the port out
    always begin
        @(go_soft);
        @(posedge ce_n);
        #(SS_NS) busy_pull_n = 1'b0;
        #(REC_NS) busy_pull_n = 1'b1;
    end

    // Store runs only with a write pending, after a short write grace
    always @(negedge hw_store_busy_n) begin
        if (pend && busy_pull_n) begin
            #(GRACE_NS) busy_pull_n = 1'b0;
            #(STORE_NS) pend = 1'b0;
            busy_pull_n = 1'b1;
        end
    end
endmodule

// file: nvh_timer.sv
// Loadable down-counter used for every wait of the host controller
`timescale 1ns/1ps
module nvh_timer #(
    parameter int WIDTH = 23,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] value,
    output logic expired
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // Load wins; otherwise count down and stop at zero
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = value;
        end else if (count != '0) begin
            next_count = count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            count <= RESET_VALUE;
        end else begin
            count <= next_count;
        end
    end

    assign expired = (count == '0);
endmodule
